// File: rtl/flash_prot_pkg.sv
// Constants for the write enable latch and sector protection block.
// Assumes a 100 MHz core clock that oversamples the serial link.
package flash_prot_pkg;
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_SECTOR_PROTECT = 8'h36;
	localparam logic [7:0] OP_SECTOR_UNPROTECT = 8'h39;
	localparam int SECTOR_COUNT = 128;
	localparam int SECTOR_IDX_W = 7;
	localparam int ADDR_W = 24;
	localparam int SECTOR_LSB = 16;
	localparam logic [5:0] BITS_OPCODE = 6'h08;
	localparam logic [5:0] BITS_ADDRESS = 6'h20;
	localparam logic [SECTOR_COUNT-1:0] PROT_RESET = '1;
	localparam logic WRITE_LATCH_RESET = 1'b0;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_OPCODE = 5'b00010,
		ST_ADDR = 5'b00100,
		ST_IGNORE = 5'b01000,
		ST_DONE = 5'b10000
	} cmd_state_t;
endpackage : flash_prot_pkg

// File: rtl/link_sampler.sv
// Two-flop synchronisers and edge detection for the serial link pins.
// Assumes sclk, csN and mosi are asynchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module link_sampler (
	input wire logic core_clk, // Core clock
	input wire logic rst, // Asynchronous reset, active high
	input wire logic sclk, // Serial clock pin
	input wire logic csN, // Chip select pin, active low
	input wire logic mosi, // Serial data in pin
	output logic sclkRise, // One-cycle pulse on serial clock rise
	output logic csFall, // One-cycle pulse at frame start
	output logic csRise, // One-cycle pulse at frame end
	output logic dataBit // Synchronised data bit
);
	logic [2:0] sclkPipe;
	logic [2:0] csPipe;
	logic [1:0] mosiPipe;

	// Only stage 1 onwards is read; stage 0 feeds stage 1 alone
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sclkPipe <= 3'h0;
			csPipe <= 3'h7;
			mosiPipe <= 2'h0;
		end else begin
			sclkPipe <= {sclkPipe[1:0], sclk};
			csPipe <= {csPipe[1:0], csN};
			mosiPipe <= {mosiPipe[0], mosi};
		end
	end

	assign sclkRise = sclkPipe[1] & ~sclkPipe[2];
	assign csFall = ~csPipe[1] & csPipe[2];
	assign csRise = csPipe[1] & ~csPipe[2];
	// Data is delayed the same two stages as the sclk edge, so aligned at the edge
	assign dataBit = mosiPipe[1];
endmodule : link_sampler
`default_nettype wire

// File: rtl/flash_write_latch_sector_protect.sv
// Write enable latch and per-sector software protection command logic.
// Assumes SPI mode 0/3 host; sclk at most a quarter of core_clk rate.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [RULE1] Opcode 06h then frame end sets latch
// [RULE2] Protect commands need latch already set
// [RULE3] Enable/disable take no address, ignore data
// [RULE4] Short or unaligned enable/disable frame aborts
// [RULE5] Opcode 04h then frame end clears latch
// [RULE6] One flag per sector, all set at reset
// [RULE7] Flag 0 accepts, 1 rejects program/erase
// [RULE8] Host sends 36h plus three address bytes
// [RULE9] Valid protect sets flag, clears latch
// [RULE10] Bad protect frame keeps flag, clears latch
// [RULE11] Locked: ignore protect, clear latch
// [RULE12] Host sends 39h plus three address bytes
// [RULE13] Valid unprotect clears flag and latch
// [RULE14] Bad unprotect frame keeps flag, clears latch
// [RULE15] Locked: ignore unprotect, clear latch
// [RULE16] Bytes after address are ignored
// [RULE17] Host issues write enable beforehand
// [RULE18] Suspended: protect opcodes fully ignored
// [RULE19] Sector chosen by upper address bits
module flash_write_latch_sector_protect
	import flash_prot_pkg::*;
(
	input wire logic core_clk, // Core clock, 100 MHz
	input wire logic rst, // Asynchronous reset, active high
	input wire logic sclk, // Serial clock from host
	input wire logic csN, // Chip select from host, active low
	input wire logic mosi, // Serial data from host
	input wire logic protRegsLock, // protection_regs_lock_bit level
	input wire logic suspended, // Program or erase suspended level
	input wire logic [SECTOR_IDX_W-1:0] querySector, // Sector to check
	output logic writeEnableLatch, // write_enable_latch state
	output logic queryWritable, // Sector accepts program/erase
	output logic [SECTOR_COUNT-1:0] sectorProtect // Protection flags
);
	logic sclkRise;
	logic csFall;
	logic csRise;
	logic dataBit;
	cmd_state_t state;
	logic [5:0] bitCount;
	logic [7:0] opcode;
	logic [ADDR_W-1:0] addr;
	logic weCapture; // Latch value seen when the command opcode completed
	logic opcodeDone;
	logic addrDone;
	logic aligned;
	logic fullOpcode;
	logic fullAddr;
	logic sectorCmd;
	logic frameEnd;
	logic commitEnable;
	logic commitDisable;
	logic commitSectorCmd;
	logic commitFlag;
	logic flagValue;
	logic [SECTOR_IDX_W-1:0] targetSector;
	wire logic [SECTOR_COUNT-1:0] sectorSelect;

	function automatic logic isSectorCmd(input logic [7:0] op);
		isSectorCmd = (op == OP_SECTOR_PROTECT) ||
			(op == OP_SECTOR_UNPROTECT);
	endfunction : isSectorCmd

	link_sampler u_sampler (
		.core_clk(core_clk),
		.rst(rst),
		.sclk(sclk),
		.csN(csN),
		.mosi(mosi),
		.sclkRise(sclkRise),
		.csFall(csFall),
		.csRise(csRise),
		.dataBit(dataBit)
	);

	// Opcode and address completion strobes, taken on the final bit's edge
	assign opcodeDone = sclkRise && (state == ST_OPCODE) &&
		(bitCount == BITS_OPCODE - 6'h01);
	assign addrDone = sclkRise && (state == ST_ADDR) &&
		(bitCount == BITS_ADDRESS - 6'h01);

	// Past the address the count wraps over 32 to 39, so a long frame is
	// still judged on its byte boundary without a wide counter
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bitCount <= 6'h00;
		end else if (csFall) begin
			bitCount <= 6'h00;
		end else if (sclkRise && state != ST_IDLE) begin
			if (bitCount >= BITS_ADDRESS) begin
				bitCount <= BITS_ADDRESS | {3'h0, bitCount[2:0] + 3'h1};
			end else begin
				bitCount <= bitCount + 6'h01;
			end
		end
	end

	// Opcode shifter; later bits of the frame never disturb it
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			opcode <= 8'h00;
		end else if (sclkRise && state == ST_OPCODE) begin
			opcode <= {opcode[6:0], dataBit};
		end
	end

	// Address shifter; bytes after the third address byte are dropped
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			addr <= 24'h00_0000;
		end else if (sclkRise && state == ST_ADDR) begin
			addr <= {addr[ADDR_W-2:0], dataBit}; // RULE16
		end
	end

	// A frame end always returns to idle, whatever state it cut short
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
		end else if (csFall) begin
			state <= ST_OPCODE;
		end else if (csRise) begin
			state <= ST_IDLE; // RULE11 RULE15
		end else begin
			case (state)
				ST_IDLE: begin
					state <= ST_IDLE;
				end
				ST_OPCODE: begin
					if (opcodeDone) begin
						// The last opcode bit is still on dataBit here
						if (isSectorCmd({opcode[6:0], dataBit})) begin
							state <= ST_ADDR;
						end else begin
							state <= ST_IGNORE; // RULE3
						end
					end
				end
				ST_ADDR: begin
					if (addrDone) begin
						state <= ST_DONE;
					end
				end
				ST_IGNORE: begin
					state <= ST_IGNORE; // RULE3
				end
				ST_DONE: begin
					state <= ST_DONE; // RULE16
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Latch is judged when the opcode completes, so nothing later in the
	// same frame can open the flags
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			weCapture <= 1'b0;
		end else if (csFall) begin
			weCapture <= 1'b0;
		end else if (opcodeDone) begin
			weCapture <= writeEnableLatch; // RULE2
		end
	end

	assign aligned = (bitCount[2:0] == 3'h0); // RULE4
	assign fullOpcode = (state != ST_OPCODE) && (state != ST_IDLE);
	assign fullAddr = (state == ST_DONE);
	assign sectorCmd = fullOpcode && isSectorCmd(opcode);
	assign targetSector = addr[SECTOR_LSB +: SECTOR_IDX_W]; // RULE19

	// Suspended frames commit nothing at all, latch included
	assign frameEnd = csRise && !suspended && fullOpcode; // RULE18
	assign commitEnable = frameEnd && aligned &&
		(opcode == OP_WRITE_ENABLE); // RULE1 RULE4
	assign commitDisable = frameEnd && aligned &&
		(opcode == OP_WRITE_DISABLE); // RULE4 RULE5
	assign commitSectorCmd = frameEnd && sectorCmd;
	// Lock check wins over address; aborted frames keep the flags
	assign commitFlag = commitSectorCmd && fullAddr && aligned &&
		weCapture && !protRegsLock; // RULE2 RULE10 RULE11 RULE14 RULE15
	assign flagValue = (opcode == OP_SECTOR_PROTECT); // RULE9 RULE13

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			writeEnableLatch <= WRITE_LATCH_RESET;
		end else if (commitEnable) begin
			writeEnableLatch <= 1'b1; // RULE1
		end else if (commitDisable) begin
			writeEnableLatch <= 1'b0; // RULE5
		end else if (commitSectorCmd) begin
			// Every protect or unprotect frame not suspended, good or bad, drops the latch
			writeEnableLatch <= 1'b0; // RULE9 RULE10 RULE13 RULE14
		end
	end

	// One select per sector; the index only reaches the flags through it
	generate
		for (genvar s = 0; s < SECTOR_COUNT; s++) begin : g_sector
			assign sectorSelect[s] = commitFlag &&
				(targetSector == SECTOR_IDX_W'(s)); // RULE19
		end
	endgenerate

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sectorProtect <= PROT_RESET; // RULE6
		end else if (commitFlag) begin
			sectorProtect <= (sectorProtect & ~sectorSelect) |
				(sectorSelect & {SECTOR_COUNT{flagValue}}); // RULE9 RULE13
		end
	end

	assign queryWritable = ~sectorProtect[querySector]; // RULE7
endmodule : flash_write_latch_sector_protect
`default_nettype wire

// File: verification/spi_host_model.sv
// SPI host model, mode 0, MSB first; clock stands still between frames.
// Assumes frames are requested one at a time.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	output logic sclk = 1'b0, // Clock
	output logic csN = 1'b1, // Select
	output logic mosi = 1'b0 // Data
);
	task automatic send(input logic [47:0] d, input int n);
		csN = 1'b0;
		for (int i = 0; i < n; i++) begin
			mosi = d[47-i];
			#62.5 sclk = 1'b1;
			#62.5 sclk = 1'b0;
		end
		#62.5 csN = 1'b1;
		mosi = ~mosi; // Released line keeps no stale bit
		#125;
	endtask : send
endmodule : spi_host_model
`default_nettype wire

// File: verification/flash_prot_assertions.sv
// Port assertions for the latch and sector protection block.
// Assumes frames are spaced by at least one serial clock period.
`timescale 1ns/1ps
`default_nettype none
module flash_prot_assertions
	import flash_prot_pkg::*;
(
	input wire logic core_clk, // Clock
	input wire logic rst, // Reset
	input wire logic csN, // Select
	input wire logic protRegsLock, // Lock
	input wire logic suspended, // Suspend
	input wire logic [SECTOR_IDX_W-1:0] querySector, // Query
	input wire logic writeEnableLatch, // Latch
	input wire logic queryWritable, // Result
	input wire logic [SECTOR_COUNT-1:0] sectorProtect // Flags
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	query_flag_a: assert property (
		queryWritable == !sectorProtect[querySector]) else $error("query");
	reset_value_a: assert property (disable iff (1'b0)
		rst |-> &sectorProtect && !writeEnableLatch) else $error("reset");
	latch_set_a: assert property (
		$rose(writeEnableLatch) |-> csN && $past(csN, 2)) else $error("set");
	latch_clear_a: assert property (
		$fell(writeEnableLatch) |-> csN && $past(csN, 2)) else $error("clr");
	flag_latch_a: assert property ($changed(sectorProtect) |->
		!writeEnableLatch && $past(writeEnableLatch, 4)) else $error("wel");
	one_sector_a: assert property ($changed(sectorProtect) |->
		$onehot(sectorProtect ^ $past(sectorProtect))) else $error("sector");
	suspend_hold_a: assert property (suspended [*6] |->
		$stable(sectorProtect) && $stable(writeEnableLatch)) else $error("s");
	lock_hold_a: assert property (protRegsLock [*6] |->
		$stable(sectorProtect)) else $error("lock");
	cover property ($changed(sectorProtect));
	cover property (suspended && $fell(csN));
	cover property (protRegsLock && $rose(csN));
endmodule : flash_prot_assertions
bind flash_write_latch_sector_protect flash_prot_assertions
	i_flash_prot_assertions (.core_clk(core_clk), .rst(rst), .csN(csN),
	.protRegsLock(protRegsLock), .suspended(suspended),
	.querySector(querySector), .writeEnableLatch(writeEnableLatch),
	.queryWritable(queryWritable), .sectorProtect(sectorProtect));
`default_nettype wire

// File: verification/test_flash_write_latch_sector_protect.sv
// Bench: directed then random frames, checked against a local model.
// Assumes the host model drives the serial pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_count++; \
	$display("CHECK FAILED %0t mismatch", $time); end end
module test_flash_write_latch_sector_protect
	import flash_prot_pkg::*;
;
	logic core_clk = 1'b0, rst = 1'b0, sclk, csN, mosi, writeEnableLatch;
	logic protRegsLock = 1'b0, suspended = 1'b0, queryWritable;
	logic expLatch = 1'b0;
	logic [SECTOR_IDX_W-1:0] querySector = '0;
	logic [SECTOR_COUNT-1:0] sectorProtect, expProt = '1;
	logic [7:0] ops [4] = '{OP_WRITE_ENABLE, OP_WRITE_DISABLE,
		OP_SECTOR_PROTECT, OP_SECTOR_UNPROTECT};
	int lens [7] = '{7, 8, 9, 24, 32, 33, 40};
	int err_count = 0, comparisons = 0, seed = 76913;
	spi_host_model i_spi_host_model (.sclk(sclk), .csN(csN), .mosi(mosi));
	flash_write_latch_sector_protect i_flash_write_latch_sector_protect (
		.core_clk(core_clk),
		.rst(rst),
		.sclk(sclk),
		.csN(csN),
		.mosi(mosi),
		.protRegsLock(protRegsLock),
		.suspended(suspended),
		.querySector(querySector),
		.writeEnableLatch(writeEnableLatch),
		.queryWritable(queryWritable),
		.sectorProtect(sectorProtect)
	);
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	task automatic give_verdict();
		$display("comparisons %0d errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	// A frame counts only if it reached need bits and ended on a byte
	function automatic logic onByte(input int n, input int need);
		return (n >= need) && (n % 8 == 0);
	endfunction : onByte
	task automatic frame(input logic [7:0] op, input logic [23:0] a,
		input int n, input logic [1:0] ls);
		@(negedge core_clk);
		{protRegsLock, suspended} = ls;
		querySector = SECTOR_IDX_W'($random(seed));
		i_spi_host_model.send({op, a, 16'h0000}, n);
		repeat (8) @(negedge core_clk);
		if (!ls[0] && n >= 8) begin
			if (op == OP_WRITE_ENABLE || op == OP_WRITE_DISABLE) begin
				if (onByte(n, 8))
					expLatch = op == OP_WRITE_ENABLE;
			end else begin
				if (expLatch && !ls[1] && onByte(n, 32))
					expProt[a[22:16]] = op == OP_SECTOR_PROTECT;
				expLatch = 1'b0;
			end
		end
		`CHK(writeEnableLatch, expLatch)
		`CHK(sectorProtect, expProt)
		`CHK(queryWritable, !expProt[querySector])
	endtask : frame
	initial begin
		#1 rst = 1'b1;
		repeat (6) @(negedge core_clk);
		rst = 1'b0;
		`CHK(sectorProtect, expProt)
		`CHK(writeEnableLatch, 1'b0)
		repeat (3) @(negedge core_clk);
		frame(OP_WRITE_ENABLE, '0, 16, 2'h0);
		frame(OP_SECTOR_UNPROTECT, 24'hA5_1234, 40, 2'h0);
		frame(OP_WRITE_ENABLE, '0, 9, 2'h0);
		frame(OP_WRITE_ENABLE, '0, 8, 2'h0);
		frame(OP_WRITE_DISABLE, '0, 8, 2'h1);
		frame(OP_SECTOR_PROTECT, 24'h25_0000, 24, 2'h0);
		frame(OP_SECTOR_PROTECT, 24'h25_0000, 32, 2'h0);
		frame(OP_WRITE_ENABLE, '0, 8, 2'h2);
		frame(OP_SECTOR_PROTECT, 24'hA5_0000, 32, 2'h2);
		frame(OP_WRITE_ENABLE, '0, 8, 2'h0);
		frame(OP_SECTOR_UNPROTECT, 24'h01_0000, 33, 2'h0);
		frame(OP_WRITE_ENABLE, '0, 8, 2'h0);
		frame(OP_SECTOR_PROTECT, 24'h25_FFFF, 32, 2'h0);
		for (int k = 0; k < 50; k++)
			frame(ops[$unsigned($random(seed)) % 4], 24'($random(seed)),
				lens[$unsigned($random(seed)) % 7], 2'($random(seed)));
		give_verdict();
	end
	initial begin
		#900000;
		err_count++;
		give_verdict();
	end
endmodule : test_flash_write_latch_sector_protect
`default_nettype wire
